/* File: rtl/fcsi_cmd_slot.v */
`include "fcsi_regs.vh"
// one-entry command buffer holding code, address and data
module fcsi_cmd_slot #(
  parameter AW = 16
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // write side
  input wire wrEn,
  input wire [7:0] cmdIn,
  input wire [AW-1:0] addrIn,
  input wire [7:0] dataIn,
  // stored entry
  output reg [7:0] cmdOut,
  output reg [AW-1:0] addrOut,
  output reg [7:0] dataOut
);

  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      cmdOut <= `FCSI_RST_CMD;
      addrOut <= {AW{1'b0}};
      dataOut <= 8'h00;
    end
    else if (wrEn)
    begin
      cmdOut <= cmdIn;
      addrOut <= addrIn;
      dataOut <= dataIn;
    end
  end

endmodule

/* File: rtl/fcsi_flash_cmd.v */
`include "fcsi_regs.vh"
module fcsi_flash_cmd #(
  parameter AW = 16
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // wishbone classic slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  // system
  input wire stopEntry,
  input wire [1:0] secInit,
  output wire [1:0] securityCode,
  // flash array
  output wire arrayGo,
  output wire [7:0] arrayCmd,
  output wire [AW-1:0] arrayAddr,
  output wire [7:0] arrayData,
  input wire arrayDone,
  input wire arrayBlank
);

  localparam [1:0] SEQ_IDLE = 2'd0;
  localparam [1:0] SEQ_DATA = 2'd1;
  localparam [1:0] SEQ_CMD = 2'd2;
  localparam PW = AW - `FCSI_PAGE_SHIFT;

  reg ack_q;
  reg [31:0] rdat_q;
  reg [1:0] seq_q;
  reg [1:0] seq_d;
  reg seqErr;
  reg [7:0] cmdReg_q;
  reg [7:0] divReg_q;
  reg divSet_q;
  reg [7:0] prot_q;
  reg [AW-1:0] arrAddr_q;
  reg [7:0] arrData_q;
  reg slotFull_q;
  reg busy_q;
  reg runBurst_q;
  reg runBlank_q;
  reg ccf_q;
  reg pviol_q;
  reg accErr_q;
  reg blank_q;
  reg [1:0] sec_q;
  reg secLoaded_q;
  reg stopPrev_q;
  reg go_q;
  reg [7:0] aCmd_q;
  reg [AW-1:0] aAddr_q;
  reg [7:0] aData_q;
  reg [31:0] rdat_d;
  wire [7:0] slotCmd;
  wire [AW-1:0] slotAddr;
  wire [7:0] slotData;
  wire [7:0] statusVal;

  // bus decode
  wire wbAcc = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wrEn = wbAcc & wb_we_i & wb_sel_i[0];
  wire wrStat = wrEn & (wb_adr_i == `FCSI_OFS_STATUS);
  wire wrCmd = wrEn & (wb_adr_i == `FCSI_OFS_CMD);
  wire wrDiv = wrEn & (wb_adr_i == `FCSI_OFS_DIV);
  wire wrProt = wrEn & (wb_adr_i == `FCSI_OFS_PROT);
  wire wrArray = wrEn & (wb_adr_i == `FCSI_OFS_ARRAY);
  wire cbef = ~slotFull_q;
  wire launchWr = wrStat & wb_dat_i[`FCSI_BIT_CBEF] & cbef;
  wire [7:0] newCmd = wb_dat_i[7:0];

  wire newLegal = (newCmd == `FCSI_CMD_BLANK) |
                  (newCmd == `FCSI_CMD_PROG) |
                  (newCmd == `FCSI_CMD_BURST) |
                  (newCmd == `FCSI_CMD_PAGE) |
                  (newCmd == `FCSI_CMD_MASS);

  wire isProg = (cmdReg_q == `FCSI_CMD_PROG) |
                (cmdReg_q == `FCSI_CMD_BURST);
  wire isErase = (cmdReg_q == `FCSI_CMD_PAGE) |
                 (cmdReg_q == `FCSI_CMD_MASS);
  wire isBurst = (cmdReg_q == `FCSI_CMD_BURST);
  wire isMass = (cmdReg_q == `FCSI_CMD_MASS);

  // launch checks
  wire launch = launchWr & (seq_q == SEQ_CMD);
  wire divErr = (isProg | isErase) & ~divSet_q;
  wire queueErr = busy_q & ~(isBurst & runBurst_q);
  // pages at or above the boundary are protected unless disabled
  wire pageHit = arrAddr_q[AW-1:`FCSI_PAGE_SHIFT] >= prot_q[7:8-PW];
  wire protHit = ~prot_q[0] &
                 ((isProg | (isErase & ~isMass)) & pageHit |
                  isMass);
  wire launchBad = launch & (divErr | queueErr);
  wire protBad = launch & ~divErr & ~queueErr & protHit;
  wire accept = launch & ~divErr & ~queueErr & ~protHit;
  wire start = slotFull_q & ~busy_q;
  wire stopErr = stopEntry & ~stopPrev_q & (busy_q | slotFull_q);
  wire accSet = seqErr | launchBad | stopErr;
  wire slotFull_d = accept | (slotFull_q & ~start);
  wire busy_d = start | (busy_q & ~arrayDone);

  // command sequence checker
  always @*
  begin
    seq_d = seq_q;
    seqErr = 1'b0;
    case (seq_q)
      SEQ_IDLE:
      begin
        if (wrArray & cbef)
          seq_d = SEQ_DATA;
        else if (wrArray | wrCmd | launchWr)
          seqErr = 1'b1;
      end
      SEQ_DATA:
      begin
        if (wrCmd & newLegal)
          seq_d = SEQ_CMD;
        else if (wrCmd | wrArray | launchWr)
        begin
          seqErr = 1'b1;
          seq_d = SEQ_IDLE;
        end
      end
      SEQ_CMD:
      begin
        if (launchWr)
          seq_d = SEQ_IDLE;
        else if (wrCmd | wrArray)
        begin
          seqErr = 1'b1;
          seq_d = SEQ_IDLE;
        end
      end
      default:
        seq_d = SEQ_IDLE;
    endcase
  end

  always @(posedge clock)
  begin
    if (!rst_n)
      seq_q <= SEQ_IDLE;
    else
      seq_q <= seq_d;
  end

  // software registers
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      cmdReg_q <= `FCSI_RST_CMD;
      divReg_q <= `FCSI_RST_DIV;
      divSet_q <= 1'b0;
      prot_q <= `FCSI_RST_PROT;
      arrAddr_q <= {AW{1'b0}};
      arrData_q <= 8'h00;
    end
    else
    begin
      if (wrCmd)
        cmdReg_q <= newCmd;
      if (wrDiv)
      begin
        divReg_q <= wb_dat_i[7:0];
        divSet_q <= 1'b1;
      end
      if (wrProt)
        prot_q <= wb_dat_i[7:0];
      if (wrArray & cbef)
      begin
        arrAddr_q <= wb_dat_i[`FCSI_ARR_ADDR_LSB +: AW];
        arrData_q <= wb_dat_i[`FCSI_ARR_DATA_LSB +: 8];
      end
    end
  end

  fcsi_cmd_slot #(
    .AW(AW)
  ) u_slot (
    .clock(clock),
    .rst_n(rst_n),
    .wrEn(accept),
    .cmdIn(cmdReg_q),
    .addrIn(arrAddr_q),
    .dataIn(arrData_q),
    .cmdOut(slotCmd),
    .addrOut(slotAddr),
    .dataOut(slotData)
  );

  // buffer and execution tracking
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      slotFull_q <= 1'b0;
      busy_q <= 1'b0;
      runBurst_q <= 1'b0;
      runBlank_q <= 1'b0;
      ccf_q <= 1'b1;
      stopPrev_q <= 1'b0;
    end
    else
    begin
      slotFull_q <= slotFull_d;
      busy_q <= busy_d;
      ccf_q <= ~slotFull_d & ~busy_d;
      stopPrev_q <= stopEntry;
      if (start)
      begin
        runBurst_q <= (slotCmd == `FCSI_CMD_BURST);
        runBlank_q <= (slotCmd == `FCSI_CMD_BLANK);
      end
    end
  end

  // hand-off to the array
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      go_q <= 1'b0;
      aCmd_q <= `FCSI_RST_CMD;
      aAddr_q <= {AW{1'b0}};
      aData_q <= 8'h00;
    end
    else
    begin
      go_q <= start;
      if (start)
      begin
        aCmd_q <= slotCmd;
        aAddr_q <= slotAddr;
        aData_q <= slotData;
      end
    end
  end

  // sticky error flags; a set in the clearing cycle wins
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      pviol_q <= 1'b0;
      accErr_q <= 1'b0;
    end
    else
    begin
      if (protBad)
        pviol_q <= 1'b1;
      else if (wrStat & wb_dat_i[`FCSI_BIT_PVIOL])
        pviol_q <= 1'b0;
      if (accSet)
        accErr_q <= 1'b1;
      else if (wrStat & wb_dat_i[`FCSI_BIT_ACCERR])
        accErr_q <= 1'b0;
    end
  end

  // blank result and security state
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      blank_q <= 1'b0;
      sec_q <= `FCSI_RST_SEC;
      secLoaded_q <= 1'b0;
    end
    else
    begin
      secLoaded_q <= 1'b1;
      if (!secLoaded_q)
        sec_q <= secInit;
      else if (arrayDone & busy_q & runBlank_q & arrayBlank)
        sec_q <= `FCSI_SEC_UNSECURED;
      if (arrayDone & busy_q & runBlank_q & arrayBlank)
        blank_q <= 1'b1;
      else if (accept)
        blank_q <= 1'b0;
    end
  end

  assign statusVal = {cbef, ccf_q, pviol_q, accErr_q,
                      1'b0, blank_q, 2'b00};

  // read mux; unmapped offsets read zero
  always @*
  begin
    rdat_d = 32'h0000_0000;
    case (wb_adr_i)
      `FCSI_OFS_STATUS:
        rdat_d[7:0] = statusVal;
      `FCSI_OFS_CMD:
        rdat_d[7:0] = cmdReg_q;
      `FCSI_OFS_DIV:
        rdat_d[7:0] = divReg_q;
      `FCSI_OFS_PROT:
        rdat_d[7:0] = prot_q;
      `FCSI_OFS_ARRAY:
      begin
        rdat_d[`FCSI_ARR_ADDR_LSB +: AW] = arrAddr_q;
        rdat_d[`FCSI_ARR_DATA_LSB +: 8] = arrData_q;
      end
      `FCSI_OFS_SEC:
        rdat_d[1:0] = sec_q;
      default:
        rdat_d = 32'h0000_0000;
    endcase
  end

  // bus answer: one wait state, ack for one cycle
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= wbAcc;
      if (wbAcc & ~wb_we_i)
        rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign securityCode = sec_q;
  assign arrayGo = go_q;
  assign arrayCmd = aCmd_q;
  assign arrayAddr = aAddr_q;
  assign arrayData = aData_q;

endmodule

/* File: rtl/fcsi_regs.vh */
`ifndef FCSI_REGS_VH
`define FCSI_REGS_VH

// register byte offsets on the bus
`define FCSI_OFS_STATUS 8'h00
`define FCSI_OFS_CMD 8'h04
`define FCSI_OFS_DIV 8'h08
`define FCSI_OFS_PROT 8'h0C
`define FCSI_OFS_ARRAY 8'h10
`define FCSI_OFS_SEC 8'h14

// status bit positions
`define FCSI_BIT_CBEF 7
`define FCSI_BIT_CCF 6
`define FCSI_BIT_PVIOL 5
`define FCSI_BIT_ACCERR 4
`define FCSI_BIT_BLANK 2

// array write register fields
`define FCSI_ARR_DATA_LSB 0
`define FCSI_ARR_ADDR_LSB 16

// command codes
`define FCSI_CMD_BLANK 8'h05
`define FCSI_CMD_PROG 8'h20
`define FCSI_CMD_BURST 8'h25
`define FCSI_CMD_PAGE 8'h40
`define FCSI_CMD_MASS 8'h41

// 512-byte page
`define FCSI_PAGE_SHIFT 9

// reset values and the unsecured security code
`define FCSI_RST_CMD 8'h00
`define FCSI_RST_DIV 8'h00
`define FCSI_RST_PROT 8'hFF
`define FCSI_RST_SEC 2'h0
`define FCSI_SEC_UNSECURED 2'h2
`endif

/* File: verification/fcsi_flash_cmd_sva.sv */
module fcsi_flash_cmd_sva (
  // bus
  input wire clock,
  input wire rst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // array and security
  input wire arrayGo,
  input wire [7:0] arrayCmd,
  input wire arrayDone,
  input wire arrayBlank,
  input wire [1:0] securityCode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  stat_rsvd_zero_a: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == 8'h00
    |-> (wb_dat_o & 32'hFFFFFF0B) == 32'h0) else $error("reserved bits set");
  go_pulse_a: assert property (arrayGo |=> !arrayGo)
    else $error("hand-off longer than one cycle");
  go_code_a: assert property (
    arrayGo |-> arrayCmd inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41})
    else $error("illegal code handed to array");
  go_busy_a: assert property (arrayGo ##1 !arrayDone |=> !arrayGo)
    else $error("hand-off while array busy");
  blank_sec_a: assert property (
    arrayDone && arrayBlank && arrayCmd == 8'h05 |=> securityCode == 2'h2)
    else $error("security code not unsecured");
  sec_hold_a: assert property (!(arrayDone && arrayBlank) && $past(rst_n, 3)
    |=> $stable(securityCode)) else $error("security code moved");
  unmapped_zero_a: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == 8'h18 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  cover property (arrayGo && arrayCmd == 8'h25);
  cover property (arrayDone && arrayBlank);
  cover property (wb_ack_o && !wb_we_i);
endmodule

bind fcsi_flash_cmd fcsi_flash_cmd_sva chk_u (.clock, .rst_n, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .arrayGo,
  .arrayCmd, .arrayDone, .arrayBlank, .securityCode);

/* File: verification/flash_command_status_interface_test.sv */
module flash_command_status_interface_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rst_n, cyc, stb, we, stopEntry, arrayDone, arrayBlank;
  logic wb_ack_o, arrayGo;
  logic [1:0] securityCode;
  logic [7:0] adr, arrayCmd, arrayData, d, c;
  logic [15:0] arrayAddr, a;
  logic [31:0] wdat, rd, wb_dat_o;
  logic [3:0] sel;
  logic [3:0] selNext = 4'hF;
  logic [7:0] codes [5] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
  integer seed = 8;
  integer n_mismatch = 0;
  integer n_checks = 0;
  integer cycleCount = 0;
  integer testNum = 0;

  fcsi_flash_cmd dut_u (.clock, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o, .wb_ack_o, .stopEntry, .secInit(2'h1), .securityCode,
    .arrayGo, .arrayCmd, .arrayAddr, .arrayData, .arrayDone, .arrayBlank);

  initial
  begin
    clock = 0;
    forever #25 clock = ~clock;
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycleCount++;
    if (cycleCount == 5000)
    begin
      n_mismatch++;
      give_verdict;
    end
  end

  // expected status byte from its flags
  function [31:0] sx(input logic e, c, p, r, b);
    sx = {24'h0, e, c, p, r, 1'b0, b, 2'b0};
  endfunction

  task chk(input [31:0] g, input [31:0] x);
    n_checks++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("Error at %0t got %h expected %h", $time, g, x);
    end
  endtask

  task tdone;
    testNum++;
    $display("test %0d done", testNum);
  endtask

  task wb(input logic w, input [7:0] ad, input [31:0] dt);
    @(posedge clock);
    cyc <= 1;
    stb <= 1;
    we <= w;
    sel <= selNext;
    adr <= ad;
    wdat <= dt;
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 0;
    stb <= 0;
  endtask

  task st(input [31:0] x);
    wb(0, 8'h00, 0);
    chk(rd, x);
  endtask

  // array write, command write, launch
  task seq(input [7:0] cd);
    a = $random(seed);
    d = $random(seed);
    wb(1, 8'h10, {a, 8'h00, d});
    wb(1, 8'h04, {24'h0, cd});
    wb(1, 8'h00, 32'h80);
  endtask

  task waitGo;
    do @(posedge clock); while (arrayGo !== 1'b1);
  endtask

  task fin(input logic b);
    @(posedge clock);
    arrayDone <= 1;
    arrayBlank <= b;
    @(posedge clock);
    arrayDone <= 0;
  endtask

  initial
  begin
    rst_n = 0;
    cyc = 0;
    stb = 0;
    we = 0;
    adr = 0;
    wdat = 0;
    sel = 4'hF;
    stopEntry = 0;
    arrayDone = 0;
    arrayBlank = 0;
    repeat (6) @(posedge clock);
    rst_n <= 1;
    st(sx(1, 1, 0, 0, 0));
    wb(0, 8'h18, 0);
    chk(rd, 0);
    seq(8'h20);
    st(sx(1, 1, 0, 1, 0));
    wb(1, 8'h00, 32'h4B);
    st(sx(1, 1, 0, 1, 0));
    wb(1, 8'h00, 32'h10);
    st(sx(1, 1, 0, 0, 0));
    wb(1, 8'h08, 32'h13);
    // byte lane 0 off: the write must be ignored
    selNext = 4'hE;
    wb(1, 8'h08, 32'h55);
    selNext = 4'hF;
    wb(0, 8'h08, 0);
    chk(rd, 32'h13);
    wb(1, 8'h04, 32'h20);
    st(sx(1, 1, 0, 1, 0));
    wb(1, 8'h00, 32'h10);
    repeat (3)
    begin
      c = $random(seed);
      if (c inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41})
        c = 8'h33;
      wb(1, 8'h10, 0);
      wb(1, 8'h04, {24'h0, c});
      st(sx(1, 1, 0, 1, 0));
      wb(1, 8'h00, 32'h10);
    end
    tdone;
    foreach (codes[i])
    begin
      seq(codes[i]);
      waitGo;
      chk({arrayCmd, arrayAddr, arrayData}, {codes[i], a, d});
      st(sx(1, 0, 0, 0, 0));
      fin(i == 0);
      st(sx(1, 1, 0, 0, i == 0));
    end
    chk({30'h0, securityCode}, 2'h2);
    wb(0, 8'h14, 0);
    chk(rd, 32'h2);
    tdone;
    seq(8'h25);
    waitGo;
    seq(8'h25);
    st(sx(0, 0, 0, 0, 0));
    fin(0);
    waitGo;
    chk(arrayAddr, a);
    st(sx(1, 0, 0, 0, 0));
    fin(0);
    st(sx(1, 1, 0, 0, 0));
    tdone;
    seq(8'h40);
    waitGo;
    seq(8'h20);
    st(sx(1, 0, 0, 1, 0));
    wb(1, 8'h00, 32'h10);
    stopEntry <= 1;
    st(sx(1, 0, 0, 1, 0));
    stopEntry <= 0;
    fin(0);
    wb(1, 8'h00, 32'h10);
    tdone;
    wb(1, 8'h0C, 0);
    seq(8'h20);
    st(sx(1, 1, 1, 0, 0));
    wb(1, 8'h00, 32'h10);
    st(sx(1, 1, 1, 0, 0));
    wb(1, 8'h00, 32'h20);
    st(sx(1, 1, 0, 0, 0));
    tdone;
    give_verdict;
  end
endmodule
